// file: verilog/nvh_consts.svh
// Timing counts and widths for the parallel nonvolatile memory host controller.
`ifndef NVH_CONSTS_SVH
`define NVH_CONSTS_SVH
`define NVH_CLK_PERIOD_NS 20
`define NVH_ADDR_W 15
`define NVH_DATA_W 8
`define NVH_SELECT_ACTIVE_MIN_NS 70
`define NVH_SELECT_ACTIVE_MAX_NS 2000
`define NVH_PRECHARGE_MIN_NS 70
`define NVH_WRITE_PULSE_MIN_NS 40
`define NVH_DATA_SETUP_MIN_NS 40
`define NVH_ACCESS_MAX_NS 70
`define NVH_OUT_HIZ_MAX_NS 15
`define NVH_SELECT_ACTIVE_CYC ((`NVH_SELECT_ACTIVE_MIN_NS + `NVH_CLK_PERIOD_NS - 1) / `NVH_CLK_PERIOD_NS)
`define NVH_SELECT_ACTIVE_MAX_CYC (`NVH_SELECT_ACTIVE_MAX_NS / `NVH_CLK_PERIOD_NS)
`define NVH_PRECHARGE_CYC ((`NVH_PRECHARGE_MIN_NS + `NVH_CLK_PERIOD_NS - 1) / `NVH_CLK_PERIOD_NS)
`define NVH_WRITE_PULSE_CYC ((`NVH_WRITE_PULSE_MIN_NS + `NVH_CLK_PERIOD_NS - 1) / `NVH_CLK_PERIOD_NS)
`define NVH_DATA_SETUP_CYC ((`NVH_DATA_SETUP_MIN_NS + `NVH_CLK_PERIOD_NS - 1) / `NVH_CLK_PERIOD_NS)
`define NVH_ACCESS_CYC ((`NVH_ACCESS_MAX_NS + `NVH_CLK_PERIOD_NS - 1) / `NVH_CLK_PERIOD_NS)
`define NVH_HIZ_CYC ((`NVH_OUT_HIZ_MAX_NS + `NVH_CLK_PERIOD_NS - 1) / `NVH_CLK_PERIOD_NS)
`endif

// file: verilog/nvh_pkg.sv
// Types shared by the nonvolatile memory host controller.
`default_nettype none
package nvh_pkg;
  typedef enum logic [4:0] {
    NVH_IDLE = 5'h01,
    NVH_SETUP = 5'h02,
    NVH_ACTIVE = 5'h04,
    NVH_FINISH = 5'h08,
    NVH_PRECHARGE = 5'h10
  } nvh_state_e;
  typedef logic [7:0] nvh_cnt_t;
endpackage
`default_nettype wire

// file: verilog/nvh_timer_if.sv
// Interface between the sequencer and its phase timer.
`timescale 1ns/100ps
`default_nettype none
interface nvh_timer_if;
  logic load;
  logic [7:0] value;
  logic done;
  modport seq (output load, output value, input done);
  modport tmr (input load, input value, output done);
endinterface
`default_nettype wire

// file: verilog/nvh_timer.sv
// Down counter that times the active and precharge phases of a memory cycle.
`timescale 1ns/100ps
`default_nettype none
module nvh_timer
(
  // Clocking.
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  // Sequencer side.
  nvh_timer_if.tmr tif
);
  import nvh_pkg::*;
  nvh_cnt_t count;
  nvh_cnt_t next_count;

  // Reload on request, otherwise count down and stop at zero.
  always_comb
  begin
    next_count = count;
    if (tif.load)
      next_count = tif.value;
    else if (count != 8'h00)
      next_count = count - 8'h01;
  end

  // Register the count.
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      count <= 8'h00;
    else if (clk_en)
      count <= next_count;
  end

  assign tif.done = (count == 8'h00) && !tif.load;
endmodule
`default_nettype wire

// file: verilog/nvh_host.sv
// Host controller that runs single read and write cycles on the memory pins.
`timescale 1ns/100ps
`default_nettype none
`include "nvh_consts.svh"
// How it works
// - Write data stands stable the data setup time before the end.
// - Select stays high at least the precharge minimum time.
// - Select goes high after four enabled clocks low; while clk_en is low it stays low.
// - Each access gets a fresh select falling edge.
// - Address may change after capture; host holds it anyway.
// - No cycle starts while supply is not good; a cycle already running completes.
// - Select low interval between 70 ns and 2000 ns; host holds four enabled clocks, no upper bound while clk_en is low.
module nvh_host
#(
  parameter int ADDR_W = `NVH_ADDR_W,
  parameter int DATA_W = `NVH_DATA_W
)
(
  // Clocking.
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  // Supply monitor.
  input wire logic supply_ok,
  // User request.
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  // Memory pins.
  output logic select_b,
  output logic write_b,
  output logic out_gate_b,
  output logic [ADDR_W-1:0] word_select_lines,
  input wire logic [DATA_W-1:0] byte_lines_in,
  output logic [DATA_W-1:0] byte_lines_out,
  output logic byte_lines_oe
);
  import nvh_pkg::*;

  localparam nvh_cnt_t ACT_CYC = 8'(`NVH_SELECT_ACTIVE_CYC);
  localparam nvh_cnt_t PRE_CYC = 8'(`NVH_PRECHARGE_CYC);
  localparam nvh_cnt_t HIZ_CYC = 8'(`NVH_HIZ_CYC);

  nvh_timer_if tif ();
  nvh_state_e state;
  nvh_state_e next_state;
  logic is_write;
  logic next_is_write;
  logic next_select_b;
  logic next_write_b;
  logic next_out_gate_b;
  logic [ADDR_W-1:0] next_addr;
  logic [DATA_W-1:0] next_wdata;
  logic next_oe;
  logic next_rsp_valid;
  logic [DATA_W-1:0] next_rdata;
  logic start;

  nvh_timer u_timer
  (
    .clock(clock),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .tif(tif.tmr)
  );

  assign req_ready = (state == NVH_IDLE) && supply_ok;
  assign start = req_valid && req_ready;

  // Sequencer: setup, select low for the active time, finish, precharge.
  always_comb
  begin
    next_state = state;
    next_is_write = is_write;
    next_select_b = select_b;
    next_write_b = write_b;
    next_out_gate_b = out_gate_b;
    next_addr = word_select_lines;
    next_wdata = byte_lines_out;
    next_oe = byte_lines_oe;
    next_rsp_valid = 1'b0;
    next_rdata = rsp_rdata;
    tif.load = 1'b0;
    tif.value = 8'h00;
    case (state)
      NVH_IDLE:
      begin
        if (start)
        begin
          // Address and write strobe settle one cycle before select falls.
          next_addr = req_addr;
          next_is_write = req_write;
          next_write_b = !req_write;
          next_wdata = req_wdata;
          next_oe = req_write;
          next_state = NVH_SETUP;
        end
      end
      NVH_SETUP:
      begin
        next_select_b = 1'b0;
        next_out_gate_b = is_write;
        tif.load = 1'b1;
        tif.value = ACT_CYC - 8'h01;
        next_state = NVH_ACTIVE;
      end
      NVH_ACTIVE:
      begin
        if (tif.done)
        begin
          // Raise all three strobes together so the write ends on one edge.
          next_select_b = 1'b1;
          next_write_b = 1'b1;
          next_out_gate_b = 1'b1;
          if (!is_write)
            next_rdata = byte_lines_in;
          next_rsp_valid = 1'b1;
          next_state = NVH_FINISH;
        end
      end
      NVH_FINISH:
      begin
        next_oe = 1'b0;
        tif.load = 1'b1;
        tif.value = PRE_CYC - 8'h02;
        next_state = NVH_PRECHARGE;
      end
      NVH_PRECHARGE:
      begin
        if (tif.done)
          next_state = NVH_IDLE;
      end
      default:
      begin
        next_state = NVH_IDLE;
        next_select_b = 1'b1;
        next_write_b = 1'b1;
        next_out_gate_b = 1'b1;
        next_oe = 1'b0;
      end
    endcase
  end

  // Register sequencer state and pins.
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      state <= NVH_IDLE;
      is_write <= 1'b0;
      select_b <= 1'b1;
      write_b <= 1'b1;
      out_gate_b <= 1'b1;
      word_select_lines <= '0;
      byte_lines_out <= '0;
      byte_lines_oe <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end
    else if (clk_en)
    begin
      state <= next_state;
      is_write <= next_is_write;
      select_b <= next_select_b;
      write_b <= next_write_b;
      out_gate_b <= next_out_gate_b;
      word_select_lines <= next_addr;
      byte_lines_out <= next_wdata;
      byte_lines_oe <= next_oe;
      rsp_valid <= next_rsp_valid;
      rsp_rdata <= next_rdata;
    end
  end

  // Select low lasts exactly the active count.
  property p_active_len;
    @(posedge clock) disable iff (!rst_b || !clk_en)
    $fell(select_b) |-> !select_b [*4] ##1 select_b;
  endproperty
  a_active_len: assert property (p_active_len) else $error("select low length wrong");

  property p_precharge;
    @(posedge clock) disable iff (!rst_b || !clk_en)
    $rose(select_b) |-> select_b [*4];
  endproperty
  a_precharge: assert property (p_precharge) else $error("precharge too short");

  property p_write_first;
    @(posedge clock) disable iff (!rst_b || !clk_en)
    ($fell(select_b) && is_write) |-> !write_b && $past(!write_b);
  endproperty
  a_write_first: assert property (p_write_first) else $error("write strobe not low before select");

  property p_gate_write;
    @(posedge clock) disable iff (!rst_b || !clk_en)
    !write_b |-> out_gate_b;
  endproperty
  a_gate_write: assert property (p_gate_write) else $error("output gate low during write");

  property p_addr_hold;
    @(posedge clock) disable iff (!rst_b || !clk_en)
    !select_b |-> $stable(word_select_lines);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved while selected");

  property p_data_drive;
    @(posedge clock) disable iff (!rst_b || !clk_en)
    (!select_b && is_write) |-> byte_lines_oe && $stable(byte_lines_out);
  endproperty
  a_data_drive: assert property (p_data_drive) else $error("write data not stable");

  property p_same_edge;
    @(posedge clock) disable iff (!rst_b || !clk_en)
    $rose(select_b) && is_write |-> $rose(write_b);
  endproperty
  a_same_edge: assert property (p_same_edge) else $error("strobes did not end together");

  property p_supply;
    @(posedge clock) disable iff (!rst_b || !clk_en)
    !supply_ok && state == NVH_IDLE |=> select_b [*2];
  endproperty
  a_supply: assert property (p_supply) else $error("select fell with supply low");

  property p_rsp;
    @(posedge clock) disable iff (!rst_b || !clk_en)
    $rose(select_b) |-> rsp_valid;
  endproperty
  a_rsp: assert property (p_rsp) else $error("no response at cycle end");
endmodule
`default_nettype wire

// file: dv/nvh_mem_model.sv
// Behavioural model of the bytewide nonvolatile memory on the host's pins.
`timescale 1ns/100ps
`default_nettype none
module nvh_mem_model
(
  // Strobes and address.
  input wire logic select_b,
  input wire logic write_b,
  input wire logic out_gate_b,
  input wire logic [14:0] word_select_lines,
  // Byte lines.
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe,
  // Host timing faults counted.
  output var int viol
);
  logic [7:0] mem [0:32767];
  logic [14:0] lat;
  logic wr_cyc = 1'h0;
  logic busy = 1'h0;
  logic data_ok = 1'h0;
  realtime t_fall = 0.0;
  realtime t_rise = -1000.0;
  realtime t_dq = 0.0;
  initial viol = 0;
  // The select fall latches the address and the cycle kind; no wait after a write.
  always @(negedge select_b)
  begin
    lat = word_select_lines;
    wr_cyc = !write_b;
    busy = 1'h1;
    data_ok = 1'h0;
    data_ok <= #70 1'h1;
    if ($realtime - t_rise < 70) viol++;
    t_fall = $realtime;
  end
  // A late write strobe turns a running read into a write.
  always @(negedge write_b)
    if (!select_b && busy) wr_cyc = 1'h1;
  // Remember when the byte lines last moved.
  always @(dq_in)
    t_dq = $realtime;
  // The first strobe rise ends the write; the select rise starts the precharge.
  always @(posedge write_b or posedge select_b)
  begin
    if (busy && wr_cyc)
    begin
      if ($realtime - t_dq < 40) viol++;
      mem[lat] = dq_in;
    end
    wr_cyc = 1'h0;
    if (select_b && busy)
    begin
      if ($realtime - t_fall < 70 || $realtime - t_fall > 2000) viol++;
      t_rise = $realtime;
      busy = 1'h0;
      data_ok = 1'h0;
    end
  end
  // Drive only in a read with the gate low; invalid data shows inverted until access time.
  assign dq_oe = busy && !wr_cyc && write_b && !out_gate_b && !select_b;
  assign dq_out = data_ok ? mem[lat] : ~mem[lat];
endmodule
`default_nettype wire

// file: dv/nvh_host_tb_top.sv
// Self-checking bench for the nonvolatile memory host controller.
`timescale 1ns/100ps
`default_nettype none
module nvh_host_tb_top;
  typedef struct packed {logic w; logic [14:0] a; logic [7:0] d;} nvh_row_s;
  logic clock = 1'h0;
  logic rst_b = 1'h0;
  logic supply_ok = 1'h1;
  logic clk_en = 1'h1;
  logic req_valid = 1'h0;
  logic req_write = 1'h0;
  logic [14:0] req_addr = 15'h0000;
  logic [7:0] req_wdata = 8'h00;
  logic [7:0] last_bus = 8'h00;
  logic req_ready, rsp_valid, select_b, write_b, out_gate_b, byte_lines_oe, mem_oe;
  logic [7:0] rsp_rdata, byte_lines_out, mem_out, bus;
  logic [14:0] word_select_lines;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  int falls = 0;
  int viol, n;
  nvh_row_s rows [6] = '{'{1'h1, 15'h7FFF, 8'hA5}, '{1'h1, 15'h0000, 8'h5A}, '{1'h0, 15'h7FFF, 8'hA5},
    '{1'h0, 15'h0000, 8'h5A}, '{1'h1, 15'h4321, 8'hC3}, '{1'h0, 15'h4321, 8'hC3}};
  // Free-running clock.
  initial
  begin
    forever #10 clock = ~clock;
  end
  // A released bus shows the inverse of its last driven value.
  assign bus = byte_lines_oe ? byte_lines_out : (mem_oe ? mem_out : ~last_bus);
  always @(posedge clock)
    if (byte_lines_oe || mem_oe) last_bus <= bus;
  nvh_host DUT (.clock(clock), .rst_b(rst_b), .clk_en(clk_en), .supply_ok(supply_ok), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .select_b(select_b), .write_b(write_b),
    .out_gate_b(out_gate_b), .word_select_lines(word_select_lines), .byte_lines_in(bus),
    .byte_lines_out(byte_lines_out), .byte_lines_oe(byte_lines_oe));
  nvh_mem_model mem (.select_b(select_b), .write_b(write_b), .out_gate_b(out_gate_b),
    .word_select_lines(word_select_lines), .dq_in(bus), .dq_out(mem_out), .dq_oe(mem_oe), .viol(viol));
  // Compare one value and count it.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Print the counts and the verdict, then stop.
  task automatic finish_test;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Offer a request until taken, then count cycles to the response.
  task automatic do_req(input nvh_row_s r);
    int k;
    req_write = r.w;
    req_addr = r.a;
    req_wdata = r.d;
    req_valid = 1'h1;
    k = 0;
    while (req_ready !== 1'h1 && k < 50)
    begin
      @(posedge clock);
      #1;
      k++;
    end
    @(posedge clock);
    #1;
    req_valid = 1'h0;
    n = 0;
    while (rsp_valid !== 1'h1 && n < 50)
    begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask
  // Cycle kind is set up before each select fall; no two drivers on the byte lines.
  always @(negedge select_b)
  begin
    falls++;
    chk({15'h0000, write_b}, {15'h0000, !byte_lines_oe});
  end
  always @(posedge clock)
    if (rst_b) chk({15'h0000, byte_lines_oe && mem_oe}, 16'h0000);
  // Cut a hang short.
  always @(posedge clock)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      miscompares++;
      finish_test();
    end
  end
  // Main sequence.
  initial
  begin
    repeat (12) @(posedge clock);
    #1;
    chk({select_b, write_b, out_gate_b, byte_lines_oe, rsp_valid}, 16'h001C);
    rst_b = 1'h1;
    foreach (rows[i])
    begin
      do_req(rows[i]);
      chk(n[15:0], 16'h0005);
      chk({7'h00, select_b, rows[i].w ? 8'h00 : rsp_rdata}, {8'h01, rows[i].w ? 8'h00 : rows[i].d});
      $display("row %0d done", i);
    end
    chk(falls[15:0], 16'h0006);
    supply_ok = 1'h0;
    req_valid = 1'h1;
    repeat (20) @(posedge clock);
    #1;
    chk({15'h0000, req_ready}, 16'h0000);
    chk(falls[15:0], 16'h0006);
    supply_ok = 1'h1;
    $display("supply test done");
    @(posedge clock);
    #1;
    req_valid = 1'h0;
    rst_b = 1'h0;
    repeat (2) @(posedge clock);
    #1;
    chk({select_b, write_b, out_gate_b, byte_lines_oe, rsp_valid}, 16'h001C);
    rst_b = 1'h1;
    @(posedge clock);
    #1;
    chk({15'h0000, req_ready}, 16'h0001);
    do_req(rows[2]);
    chk({8'h00, rsp_rdata}, 16'h00A5);
    $display("reset test done");
    // Freeze a read in mid-access: select must hold low and the answer comes three cycles later.
    fork
      do_req(rows[3]);
      begin
        @(negedge select_b);
        @(posedge clock);
        #1;
        clk_en = 1'h0;
        repeat (3) @(posedge clock);
        #1;
        chk({15'h0000, select_b}, 16'h0000);
        clk_en = 1'h1;
      end
    join
    chk(n[15:0], 16'h0008);
    chk({8'h00, rsp_rdata}, 16'h005A);
    $display("clock enable test done");
    chk(viol[15:0], 16'h0000);
    finish_test();
  end
endmodule
`default_nettype wire
